// File: rtl/bbs_sequencer.sv
// module: boost/bypass mode sequencer
`timescale 1ns/10ps
`default_nettype none
module bbs_sequencer #(
	parameter int LINEAR_START_PHASE_TWO_TIMEOUT_CYC  = bbs_pkg::LINEAR_START_PHASE_TWO_TIMEOUT_CYC,
	parameter int SS_TIMEOUT_CYC    = bbs_pkg::SS_TIMEOUT_CYC,
	parameter int RESTART_DELAY_CYC = bbs_pkg::RESTART_DELAY_CYC,
	parameter int LINEAR_START_PHASE_ONE_MIN_CYC      = bbs_pkg::LINEAR_START_PHASE_ONE_MIN_CYC
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic enable,
	input  wire logic forced_bypass_n,
	input  wire logic output_level_select,
	input  wire logic vin_above_uvlo,
	input  wire logic vin_above_vout,
	input  wire logic vout_at_target,
	input  wire logic vin_above_target,
	input  wire logic over_current_protect,
	input  wire logic temp_above_high,
	input  wire logic temp_below_low,
	input  wire logic pwm_on_req,
	output logic      bypass_switch_on,
	output logic      linear_start_phase_one,
	output logic      linear_start_phase_two,
	output logic      soft_start_active,
	output logic      boost_switching,
	output logic      high_side_on,
	output logic      path_open,
	output logic      target_level,
	output logic      power_good_out,
	output logic      power_good_oe,
	output logic      over_temp_latched
);
	// ----------------------------------------
	// state and timer
	// ----------------------------------------
	bbs_pkg::bbs_state_t state_r, state_nxt;
	logic [bbs_pkg::TMR_W-1:0] tmr_r;
	logic otp_r;
	logic ocp_hold_r;

	function automatic logic tmr_past(input logic [bbs_pkg::TMR_W-1:0] t, input int lim);
		tmr_past = (int'(t) >= lim);
	endfunction

	wire linear_start_phase_one_done   = tmr_past(tmr_r, LINEAR_START_PHASE_ONE_MIN_CYC) && !vin_above_vout;
	wire linear_start_phase_two_expire = tmr_past(tmr_r, LINEAR_START_PHASE_TWO_TIMEOUT_CYC);
	wire ss_expire   = tmr_past(tmr_r, SS_TIMEOUT_CYC);
	wire rst_expire  = tmr_past(tmr_r, RESTART_DELAY_CYC);
	wire auto_mode   = enable && forced_bypass_n;
	// over-temperature latches; release needs the lower threshold, giving hysteresis
	wire otp_nxt     = temp_above_high ? 1'b1 : (temp_below_low ? 1'b0 : otp_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bbs_pkg::ST_SHUTDOWN: begin
				if (enable && !forced_bypass_n)
					state_nxt = bbs_pkg::ST_FORCED_PASS;
				else if (auto_mode && vin_above_uvlo)
					state_nxt = bbs_pkg::ST_LIN_ONE;
			end
			bbs_pkg::ST_FORCED_PASS: begin
				if (forced_bypass_n)
					state_nxt = bbs_pkg::ST_LIN_ONE;
			end
			bbs_pkg::ST_LIN_ONE: begin
				if (linear_start_phase_one_done)
					state_nxt = bbs_pkg::ST_LIN_TWO;
			end
			bbs_pkg::ST_LIN_TWO: begin
				if (linear_start_phase_two_expire)
					state_nxt = bbs_pkg::ST_FAULT;
				else if (!vin_above_vout)
					state_nxt = bbs_pkg::ST_SOFT_START;
			end
			bbs_pkg::ST_SOFT_START: begin
				if (ss_expire)
					state_nxt = bbs_pkg::ST_FAULT;
				else if (vout_at_target)
					state_nxt = bbs_pkg::ST_BOOST;
			end
			bbs_pkg::ST_BOOST: begin
				if (vin_above_target)
					state_nxt = bbs_pkg::ST_BYPASS;
			end
			bbs_pkg::ST_BYPASS: begin
				if (!vin_above_target)
					state_nxt = bbs_pkg::ST_BOOST;
			end
			bbs_pkg::ST_FAULT: begin
				if (rst_expire)
					state_nxt = bbs_pkg::ST_LIN_ONE;
			end
			default: state_nxt = bbs_pkg::ST_SHUTDOWN;
		endcase
		// mode pins override everything; enable low wins over all
		if (!enable)
			state_nxt = bbs_pkg::ST_SHUTDOWN;
		else if (!forced_bypass_n)
			state_nxt = bbs_pkg::ST_FORCED_PASS;
		else if (otp_nxt && state_nxt != bbs_pkg::ST_FAULT && state_r != bbs_pkg::ST_FAULT)
			state_nxt = bbs_pkg::ST_SHUTDOWN;
	end

	// ----------------------------------------
	// output decode
	// ----------------------------------------
	wire s_boost   = (state_nxt == bbs_pkg::ST_BOOST);
	wire s_bypass  = (state_nxt == bbs_pkg::ST_BYPASS) || (state_nxt == bbs_pkg::ST_FORCED_PASS);
	wire s_ss      = (state_nxt == bbs_pkg::ST_SOFT_START);
	wire switching = s_boost || s_ss;
	wire pg_ok     = (s_boost || (state_nxt == bbs_pkg::ST_BYPASS)) && !otp_nxt;
	// current limit clears the hold only once the inductor current has fallen
	wire ocp_hold_nxt = (high_side_on && over_current_protect) ? 1'b1
	                  : (over_current_protect ? ocp_hold_r : 1'b0);
	wire hs_nxt       = switching && pwm_on_req && !ocp_hold_nxt && !over_current_protect;

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r    <= bbs_pkg::ST_SHUTDOWN;
			tmr_r      <= '0;
			otp_r      <= 1'b0;
			ocp_hold_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			// saturating so long waits never wrap back under a limit
			tmr_r      <= (state_nxt != state_r) ? '0
			            : (&tmr_r ? tmr_r : tmr_r + 1'b1);
			otp_r      <= otp_nxt;
			ocp_hold_r <= ocp_hold_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bypass_switch_on       <= 1'b0;
			linear_start_phase_one <= 1'b0;
			linear_start_phase_two <= 1'b0;
			soft_start_active      <= 1'b0;
			boost_switching        <= 1'b0;
			high_side_on           <= 1'b0;
			path_open              <= 1'b1;
			target_level           <= bbs_pkg::LEVEL_LOW_3V15;
			power_good_out         <= 1'b0;
			power_good_oe          <= 1'b1;
			over_temp_latched      <= 1'b0;
		end else begin
			bypass_switch_on       <= s_bypass;
			linear_start_phase_one <= (state_nxt == bbs_pkg::ST_LIN_ONE);
			linear_start_phase_two <= (state_nxt == bbs_pkg::ST_LIN_TWO);
			soft_start_active      <= s_ss;
			boost_switching        <= switching;
			high_side_on           <= hs_nxt;
			path_open              <= (state_nxt == bbs_pkg::ST_FAULT)
			                       || (state_nxt == bbs_pkg::ST_SHUTDOWN);
			target_level           <= output_level_select;
			power_good_out         <= 1'b0;
			// open drain: pulled low unless good and no current limit event
			power_good_oe          <= !(pg_ok && !ocp_hold_nxt);
			over_temp_latched      <= otp_nxt;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence seq_en_drop;
		!enable;
	endsequence

	AST_EN_LOW_SHUTDOWN: assert property (@(posedge clock) disable iff (srst)
		seq_en_drop |=> state_r == bbs_pkg::ST_SHUTDOWN && path_open && !boost_switching)
		else $error("enable low did not shut down");
	AST_FORCED_PASS: assert property (@(posedge clock) disable iff (srst)
		enable && !forced_bypass_n |=> bypass_switch_on && !boost_switching && !soft_start_active)
		else $error("forced pass-through not taken");
	AST_AUTO_NOT_FORCED: assert property (@(posedge clock) disable iff (srst)
		!(enable && forced_bypass_n) |=> state_r != bbs_pkg::ST_BOOST)
		else $error("boost outside automatic mode");
	AST_LIN_ORDER: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_LIN_TWO && $past(state_r) != bbs_pkg::ST_LIN_TWO
		|-> $past(state_r) == bbs_pkg::ST_LIN_ONE)
		else $error("phase two not preceded by phase one");
	AST_LINEAR_START_PHASE_TWO_TIMEOUT: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_LIN_TWO && enable && forced_bypass_n && !otp_nxt
		&& int'(tmr_r) >= LINEAR_START_PHASE_TWO_TIMEOUT_CYC |=> state_r == bbs_pkg::ST_FAULT)
		else $error("phase two timeout missed");
	AST_SS_TIMEOUT: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_SOFT_START && enable && forced_bypass_n && !otp_nxt
		&& int'(tmr_r) >= SS_TIMEOUT_CYC |=> state_r == bbs_pkg::ST_FAULT)
		else $error("soft-start timeout missed");
	AST_FAULT_RESTART: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FAULT && int'(tmr_r) >= RESTART_DELAY_CYC && enable
		&& forced_bypass_n |=> state_r == bbs_pkg::ST_LIN_ONE && tmr_r == '0)
		else $error("restart not into phase one");
	AST_FAULT_OPEN: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FAULT |-> path_open && !bypass_switch_on)
		else $error("path not open in fault");
	AST_PG_HOT: assert property (@(posedge clock) disable iff (srst)
		temp_above_high |=> power_good_oe && over_temp_latched)
		else $error("power good not pulled low when hot");
	AST_OCP_HOLD: assert property (@(posedge clock) disable iff (srst)
		high_side_on && over_current_protect |=> !high_side_on && power_good_oe)
		else $error("on pulse not suppressed after over-current");
	AST_TMR_CLEAR: assert property (@(posedge clock) disable iff (srst)
		state_r != $past(state_r) |-> tmr_r == '0)
		else $error("timer not cleared on state change");

	// ----------------------------------------
	// checks on mode decode and sequencing
	// ----------------------------------------
	// the mode pins can pre-empt any step and the latch any step that neither enters nor leaves fault, so each step check is qualified
	wire run_ok = enable && forced_bypass_n && !otp_nxt;

	sequence seq_lin_exit;
		state_r == bbs_pkg::ST_LIN_TWO && !vin_above_vout && run_ok
		&& int'(tmr_r) < LINEAR_START_PHASE_TWO_TIMEOUT_CYC;
	endsequence

	sequence seq_ss_done;
		state_r == bbs_pkg::ST_SOFT_START && vout_at_target && run_ok
		&& int'(tmr_r) < SS_TIMEOUT_CYC && !over_current_protect;
	endsequence

	AST_SHUTDOWN_ALL_OFF: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_SHUTDOWN |-> path_open && !bypass_switch_on && !high_side_on
		&& !linear_start_phase_one && !linear_start_phase_two && !soft_start_active)
		else $error("shutdown left a function on");
	AST_RESTART_OFF: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FAULT && !enable |=> state_r == bbs_pkg::ST_SHUTDOWN)
		else $error("fault with enable low not shut down");
	AST_FORCED_NO_LIN: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FORCED_PASS |-> bypass_switch_on && !path_open && !high_side_on
		&& !linear_start_phase_one && !linear_start_phase_two)
		else $error("converter active in forced pass-through");
	AST_BYPASS_TO_BOOST: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_BYPASS && !vin_above_target && run_ok
		|=> state_r == bbs_pkg::ST_BOOST && !bypass_switch_on && boost_switching)
		else $error("bypass did not return to boost");
	AST_SHUTDOWN_TO_LIN: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_SHUTDOWN && vin_above_uvlo && run_ok
		|=> linear_start_phase_one && !path_open)
		else $error("automatic start did not enter phase one");
	AST_UVLO_HOLD: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_SHUTDOWN && !vin_above_uvlo |=> !linear_start_phase_one)
		else $error("phase one started below undervoltage threshold");
	AST_LINEAR_START_PHASE_ONE_MIN: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_LIN_ONE && int'(tmr_r) < LINEAR_START_PHASE_ONE_MIN_CYC |=> !linear_start_phase_two)
		else $error("phase one left too early");
	AST_LINEAR_START_PHASE_TWO_TO_SS: assert property (@(posedge clock) disable iff (srst)
		seq_lin_exit |=> soft_start_active && boost_switching && !linear_start_phase_two)
		else $error("soft-start not entered after phase two");
	AST_SS_ONLY_AFTER_LIN: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_SOFT_START && $past(state_r) != bbs_pkg::ST_SOFT_START
		|-> $past(state_r) == bbs_pkg::ST_LIN_TWO)
		else $error("soft-start entered without linear startup");
	AST_BOOST_TO_BYPASS: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_BOOST && vin_above_target && run_ok
		|=> state_r == bbs_pkg::ST_BYPASS && bypass_switch_on && !boost_switching)
		else $error("boost did not move to bypass");
	AST_LEVEL_HIGH: assert property (@(posedge clock) disable iff (srst)
		output_level_select |=> target_level == bbs_pkg::LEVEL_HIGH_3V6)
		else $error("high target level not taken");
	AST_LEVEL_LOW: assert property (@(posedge clock) disable iff (srst)
		!output_level_select |=> target_level == bbs_pkg::LEVEL_LOW_3V15)
		else $error("low target level not taken");
	AST_PG_AFTER_SS: assert property (@(posedge clock) disable iff (srst)
		seq_ss_done |=> !power_good_oe && state_r == bbs_pkg::ST_BOOST)
		else $error("power good not released after soft-start");
	AST_PG_ONLY_GOOD: assert property (@(posedge clock) disable iff (srst)
		!power_good_oe |-> state_r == bbs_pkg::ST_BOOST || state_r == bbs_pkg::ST_BYPASS)
		else $error("power good released outside regulation");
	AST_PG_FAULT: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FAULT |-> power_good_oe)
		else $error("power good released in fault");
	AST_PG_OCP: assert property (@(posedge clock) disable iff (srst)
		ocp_hold_r |-> power_good_oe)
		else $error("power good released during current limit");
	AST_PG_COOL: assert property (@(posedge clock) disable iff (srst)
		over_temp_latched |-> power_good_oe)
		else $error("power good released while over temperature");
	AST_OTP_RELEASE: assert property (@(posedge clock) disable iff (srst)
		over_temp_latched && temp_below_low && !temp_above_high |=> !over_temp_latched)
		else $error("over-temperature latch not released when cool");
	AST_OTP_HOLD: assert property (@(posedge clock) disable iff (srst)
		over_temp_latched && !temp_below_low |=> over_temp_latched)
		else $error("over-temperature latch released too early");
	AST_OTP_OFF: assert property (@(posedge clock) disable iff (srst)
		over_temp_latched |-> !boost_switching && !high_side_on)
		else $error("regulating while over temperature");
	AST_OCP_STAYS: assert property (@(posedge clock) disable iff (srst)
		ocp_hold_r && over_current_protect |=> !high_side_on)
		else $error("on pulse while current still above limit");
	AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (srst)
		state_r == bbs_pkg::ST_FAULT && int'(tmr_r) < RESTART_DELAY_CYC && enable
		&& forced_bypass_n |=> state_r == bbs_pkg::ST_FAULT && path_open)
		else $error("restart before the delay ran out");
endmodule
`default_nettype wire

// File: rtl/bbs_pkg.sv
// package: constants and state type for the boost/bypass mode sequencer
package bbs_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ           = 250;
	localparam int LINEAR_START_PHASE_TWO_TIMEOUT_US   = 1024;
	localparam int SS_TIMEOUT_MS     = 2;
	localparam int RESTART_DELAY_MS  = 1;
	localparam int LINEAR_START_PHASE_ONE_MIN_US       = 10;
	localparam int LINEAR_START_PHASE_TWO_TIMEOUT_CYC  = LINEAR_START_PHASE_TWO_TIMEOUT_US * CLK_MHZ;
	localparam int SS_TIMEOUT_CYC    = SS_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int RESTART_DELAY_CYC = RESTART_DELAY_MS * 1000 * CLK_MHZ;
	localparam int LINEAR_START_PHASE_ONE_MIN_CYC      = LINEAR_START_PHASE_ONE_MIN_US * CLK_MHZ;
	localparam int TMR_W             = 20;
	// ----------------------------------------
	// output level codes
	// ----------------------------------------
	localparam logic LEVEL_LOW_3V15 = 1'b0;
	localparam logic LEVEL_HIGH_3V6 = 1'b1;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_FORCED_PASS,
		ST_LIN_ONE,
		ST_LIN_TWO,
		ST_SOFT_START,
		ST_BOOST,
		ST_BYPASS,
		ST_FAULT
	} bbs_state_t;
endpackage

// File: testbench/bbs_host_model.sv
// host-side model driving the mode and level pins of the sequencer
`timescale 1ns/10ps
`default_nettype none
module bbs_host_model #(
	parameter int AUTO_WAIT_CYC = 15001
) (
	input  wire logic clock,
	input  wire logic want_on,
	input  wire logic want_auto,
	input  wire logic want_high,
	output logic      enable,
	output logic      forced_bypass_n,
	output logic      output_level_select
);
	int unsigned on_cyc;
	// pins move on the falling edge, well away from the sampling edge
	always @(negedge clock) begin
		enable <= want_on;
		output_level_select <= want_high;
		on_cyc <= want_on ? on_cyc + 1 : 0;
		// auto mode is held back until enable has been high over 60 us
		forced_bypass_n <= want_auto && (on_cyc > AUTO_WAIT_CYC);
	end
endmodule
`default_nettype wire

// File: testbench/bbs_sequencer_tb.sv
// self-checking testbench for the boost/bypass mode sequencer
`timescale 1ns/10ps
`default_nettype none
module bbs_sequencer_tb;
	logic clock, srst, want_on, want_auto, want_high;
	logic uvlo, vin_gt_vout, at_target, vin_gt_target, oc, t_high, t_low, pwm;
	wire logic enable, fbyp_n, lvl_sel, target_level, pg_out;
	wire logic [8:0] obs;
	int n_errors = 0;
	int comparisons = 0;
	int waited, cycles = 0;
	bbs_host_model bbs_host_model_i (.clock(clock), .want_on(want_on), .want_auto(want_auto),
		.want_high(want_high), .enable(enable), .forced_bypass_n(fbyp_n),
		.output_level_select(lvl_sel));
	// small counts keep the timeout scenarios short
	bbs_sequencer #(.LINEAR_START_PHASE_TWO_TIMEOUT_CYC(20), .SS_TIMEOUT_CYC(40), .RESTART_DELAY_CYC(10),
		.LINEAR_START_PHASE_ONE_MIN_CYC(3)) bbs_sequencer_i (.clock(clock), .srst(srst), .enable(enable),
		.forced_bypass_n(fbyp_n), .output_level_select(lvl_sel), .vin_above_uvlo(uvlo),
		.vin_above_vout(vin_gt_vout), .vout_at_target(at_target),
		.vin_above_target(vin_gt_target), .over_current_protect(oc),
		.temp_above_high(t_high), .temp_below_low(t_low), .pwm_on_req(pwm),
		.bypass_switch_on(obs[0]), .linear_start_phase_one(obs[1]),
		.linear_start_phase_two(obs[2]), .soft_start_active(obs[3]),
		.boost_switching(obs[4]), .high_side_on(obs[5]), .path_open(obs[6]),
		.target_level(target_level), .power_good_out(pg_out), .power_good_oe(obs[7]),
		.over_temp_latched(obs[8]));
	// ----------------------------------------
	// checking tasks
	// ----------------------------------------
	task automatic chk(input bit ok);
		comparisons++;
		if (!ok) begin
			n_errors++;
			$display("wrong value at %0t: output mismatch", $time);
		end
	endtask
	// bounded wait; the auto-mode delay of the host sets the bound
	task automatic await(input int k, input logic v);
		waited = 0;
		while (obs[k] !== v && waited < 20000) begin
			@(negedge clock);
			waited++;
		end
		chk(obs[k] === v);
	endtask
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles > 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		{srst, want_on, want_auto, want_high} = 4'h8;
		{uvlo, vin_gt_vout, at_target, vin_gt_target, oc, t_high, t_low, pwm} = 8'h00;
		repeat (4) @(negedge clock);
		srst = 1'b0;
		chk(obs[6] === 1'b1 && obs[7] === 1'b1 && pg_out === 1'b0);
		{uvlo, vin_gt_vout, want_on} = 3'h7;
		await(0, 1'b1);
		chk(obs[4] === 1'b0 && obs[1] === 1'b0);
		want_on = 1'b0;
		await(6, 1'b1);
		chk(obs[0] === 1'b0 && obs[4] === 1'b0);
		{want_on, want_auto, want_high} = 3'h7;
		await(1, 1'b1);
		chk(obs[6] === 1'b0 && target_level === 1'b1);
		vin_gt_vout = 1'b0;
		await(2, 1'b1);
		vin_gt_vout = 1'b1;
		await(6, 1'b1);
		chk(waited >= 18 && waited <= 22);
		vin_gt_vout = 1'b0;
		await(1, 1'b1);
		chk(waited >= 8 && waited <= 12);
		await(3, 1'b1);
		chk(obs[4] === 1'b1 && obs[7] === 1'b1);
		await(6, 1'b1);
		chk(waited >= 38 && waited <= 42);
		await(3, 1'b1);
		at_target = 1'b1;
		await(7, 1'b0);
		chk(obs[4] === 1'b1 && obs[0] === 1'b0);
		vin_gt_target = 1'b1;
		await(0, 1'b1);
		chk(obs[7] === 1'b0);
		vin_gt_target = 1'b0;
		await(0, 1'b0);
		pwm = 1'b1;
		await(5, 1'b1);
		oc = 1'b1;
		await(5, 1'b0);
		chk(obs[7] === 1'b1);
		oc = 1'b0;
		await(5, 1'b1);
		t_high = 1'b1;
		await(8, 1'b1);
		chk(obs[7] === 1'b1 && obs[4] === 1'b0);
		t_high = 1'b0;
		repeat (5) @(negedge clock);
		chk(obs[8] === 1'b1 && obs[7] === 1'b1);
		uvlo = 1'b0;
		t_low = 1'b1;
		await(8, 1'b0);
		repeat (4) @(negedge clock);
		chk(obs[1] === 1'b0 && obs[6] === 1'b1);
		uvlo = 1'b1;
		await(1, 1'b1);
		await(7, 1'b0);
		want_high = 1'b0;
		repeat (3) @(negedge clock);
		chk(target_level === 1'b0);
		at_target = 1'b0;
		t_low = 1'b0;
		t_high = 1'b1;
		await(8, 1'b1);
		t_high = 1'b0;
		t_low = 1'b1;
		await(3, 1'b1);
		await(6, 1'b1);
		want_on = 1'b0;
		repeat (20) @(negedge clock);
		chk(obs[6] === 1'b1 && obs[1] === 1'b0 && obs[0] === 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
